// ---- hdl/rrts_regs.vh ----
// Constants for the range test sequencer
`ifndef RRTS_REGS_VH
`define RRTS_REGS_VH
// Mode codes on mode_select_in
`define RRTS_MODE_IDLE      2'h0
`define RRTS_MODE_SINGLE    2'h1
`define RRTS_MODE_CYCLE     2'h2
`define RRTS_MODE_RANGE     2'h3
// Step codes
`define RRTS_STEP_REF       3'h0
`define RRTS_STEP_V0        3'h1
`define RRTS_STEP_V90       3'h2
`define RRTS_STEP_I0        3'h3
`define RRTS_STEP_I90       3'h4
// Display item codes
`define RRTS_DISP_NONE      3'h0
`define RRTS_DISP_BANNER    3'h1
`define RRTS_DISP_STEP      3'h2
`define RRTS_DISP_RESULT    3'h3
`define RRTS_DISP_VGAIN     3'h4
`define RRTS_DISP_IGAIN     3'h5
// Reference window limits
`define RRTS_REF_LOW        16'h6f00
`define RRTS_REF_HIGH       16'h8b00
// Impedance class codes
`define RRTS_Z_LT4          3'h0
`define RRTS_Z_4_40         3'h1
`define RRTS_Z_40_4K        3'h2
`define RRTS_Z_4K_40K       3'h3
`define RRTS_Z_40K_400K     3'h4
`define RRTS_Z_GT400K       3'h5
// Banner (1000 ns at 8 ns clock) and step dwell times
`define RRTS_BANNER_CYC     16'h007d
`define RRTS_CYCLE_DWELL    8'h40
`endif

// ---- hdl/rrts_sequencer.v ----
// Measurement step and range test sequencer
`timescale 1ns/1ns
`include "rrts_regs.vh"

// Contract
// - Single-step test shows banner briefly, then reference step; key shows its result
// - Reference result outside 6F00..8B00 flags an analog path fault
// - Each later step: one key announces it, next key shows result, in order
// - After last current step show voltage then current gain code, then end
// - Lowest voltage and current gain codes both mean minus 20 dB
// - Full-cycle test shows banner then runs cycle without showing the result
// - Reference measurement is shown as voltage gain code 0
// - Voltage gain codes 1 to 3 are -20, 0, +20 dB
// - Current gain codes 1 to 4 are -20, 0, +20, +40 dB
// - Range test shows banner, then holds reference setting with voltage code 0
// - Range test walks voltage then current ranges, ends after +40 dB
// - Line encoding for inhibit and voltage codes 1 to 3
// - Line encoding for current codes 1 to 4
// - Phase line low for 0 degree and inhibit, high for 90; 0 first
// - Five steps: reference, voltage 0, voltage 90, current 0, current 90
// - Displayed value is upper 16 bits of the integrating counter
// - Range is chosen automatically from the component, except in range test, where key presses step it
module rrts_sequencer (
	input  wire        clock_in,
	input  wire        reset_in,
	input  wire [1:0]  mode_select_in,
	input  wire        start_in,
	input  wire        key_press_in,
	input  wire [2:0]  impedance_class_in,
	input  wire [23:0] integrator_count_in,
	output reg         amp_gain_select_a_out,
	output reg         amp_gain_select_b_out,
	output reg         voltage_input_select_out,
	output reg         current_converter_gain_out,
	output reg         phase_select_out,
	output reg  [2:0]  step_out,
	output reg  [2:0]  voltage_gain_code_out,
	output reg  [2:0]  current_gain_code_out,
	output reg  [2:0]  display_item_out,
	output reg  [15:0] display_value_out,
	output reg         ref_fault_out,
	output reg         busy_out,
	output reg         done_out
);

	// ****************************************
	// States
	// ****************************************
	localparam [7:0] ST_IDLE   = 8'h01;
	localparam [7:0] ST_BANNER = 8'h02;
	localparam [7:0] ST_ANNOUN = 8'h04;
	localparam [7:0] ST_RESULT = 8'h08;
	localparam [7:0] ST_VGAIN  = 8'h10;
	localparam [7:0] ST_IGAIN  = 8'h20;
	localparam [7:0] ST_CYCLE  = 8'h40;
	localparam [7:0] ST_RANGE  = 8'h80;

	localparam [15:0] BANNER_CYC = `RRTS_BANNER_CYC;

	reg [7:0]  state_q;
	reg [1:0]  mode_q;
	reg [2:0]  step_q;
	reg [3:0]  range_q;
	reg [15:0] timer_q;
	reg [7:0]  dwell_q;
	reg [2:0]  sel_vcode;
	reg [2:0]  sel_icode;
	reg [2:0]  act_vcode;
	reg [2:0]  act_icode;
	reg        act_volt;
	reg        line_a;
	reg        line_b;
	reg        line_vis;
	reg        line_ivc;
	wire [15:0] count_msb;

	assign count_msb = integrator_count_in[23:8];

	// ****************************************
	// Automatic gain choice
	// ****************************************
	// impedance to gain pair
	always @* begin
		sel_vcode = 3'h1;
		sel_icode = 3'h1;
		case (impedance_class_in)
			`RRTS_Z_LT4: begin
				sel_vcode = 3'h3;
			end
			`RRTS_Z_4_40: begin
				sel_vcode = 3'h2;
			end
			`RRTS_Z_4K_40K: begin
				sel_icode = 3'h2;
			end
			`RRTS_Z_40K_400K: begin
				sel_icode = 3'h3;
			end
			`RRTS_Z_GT400K: begin
				sel_icode = 3'h4;
			end
			default: sel_vcode = 3'h1;
		endcase
	end

	// ****************************************
	// Active codes for the line encoder
	// ****************************************
	always @* begin
		act_vcode = 3'h0;
		act_icode = 3'h0;
		act_volt  = 1'b1;
		if (state_q == ST_RANGE) begin
			if (range_q < 4'h4) begin
				act_vcode = range_q[2:0];
			end else begin
				act_volt  = 1'b0;
				act_icode = range_q[2:0] - 3'h3;
			end
		end else if (step_q == `RRTS_STEP_V0 || step_q == `RRTS_STEP_V90) begin
			act_vcode = sel_vcode;
		end else if (step_q == `RRTS_STEP_I0 || step_q == `RRTS_STEP_I90) begin
			act_volt  = 1'b0;
			act_icode = sel_icode;
		end
	end

	// ****************************************
	// Line encoding
	// ****************************************
	// code to control lines
	always @* begin
		line_a   = 1'b0;
		line_b   = 1'b0;
		line_vis = 1'b0;
		line_ivc = 1'b0;
		if (act_volt) begin
			line_vis = (act_vcode != 3'h0);
			line_a   = act_vcode[0];
			line_b   = act_vcode[1];
		end else begin
			line_a   = (act_icode == 3'h1) || (act_icode == 3'h4);
			line_b   = (act_icode != 3'h1);
			line_ivc = (act_icode == 3'h3) || (act_icode == 3'h4);
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			state_q                    <= ST_IDLE;
			mode_q                     <= `RRTS_MODE_IDLE;
			step_q                     <= `RRTS_STEP_REF;
			range_q                    <= 4'h0;
			timer_q                    <= 16'h0000;
			dwell_q                    <= 8'h00;
			amp_gain_select_a_out      <= 1'b0;
			amp_gain_select_b_out      <= 1'b0;
			voltage_input_select_out   <= 1'b0;
			current_converter_gain_out <= 1'b0;
			phase_select_out           <= 1'b0;
			step_out                   <= `RRTS_STEP_REF;
			voltage_gain_code_out      <= 3'h0;
			current_gain_code_out      <= 3'h0;
			display_item_out           <= `RRTS_DISP_NONE;
			display_value_out          <= 16'h0000;
			ref_fault_out              <= 1'b0;
			busy_out                   <= 1'b0;
			done_out                   <= 1'b0;
		end else begin
			amp_gain_select_a_out      <= line_a;
			amp_gain_select_b_out      <= line_b;
			voltage_input_select_out   <= line_vis;
			current_converter_gain_out <= line_ivc;
			// phase high only on 90 degree steps
			phase_select_out <= (state_q != ST_RANGE) &&
				(step_q == `RRTS_STEP_V90 || step_q == `RRTS_STEP_I90);
			step_out              <= step_q;
			voltage_gain_code_out <= act_vcode;
			current_gain_code_out <= act_icode;
			done_out              <= 1'b0;
			busy_out              <= (state_q != ST_IDLE);
			case (state_q)
				ST_IDLE: begin
					display_item_out <= `RRTS_DISP_NONE;
					step_q           <= `RRTS_STEP_REF;
					range_q          <= 4'h0;
					if (start_in && mode_select_in != `RRTS_MODE_IDLE) begin
						mode_q           <= mode_select_in;
						timer_q          <= BANNER_CYC;
						ref_fault_out    <= 1'b0;
						state_q          <= ST_BANNER;
						display_item_out <= `RRTS_DISP_BANNER;
					end
				end
				ST_BANNER: begin
					if (timer_q == 16'h0001) begin
						dwell_q <= `RRTS_CYCLE_DWELL;
						if (mode_q == `RRTS_MODE_SINGLE) begin
							state_q          <= ST_ANNOUN;
							display_item_out <= `RRTS_DISP_STEP;
						end else if (mode_q == `RRTS_MODE_CYCLE) begin
							state_q          <= ST_CYCLE;
							display_item_out <= `RRTS_DISP_NONE;
						end else begin
							state_q           <= ST_RANGE;
							display_item_out  <= `RRTS_DISP_VGAIN;
							display_value_out <= 16'h0000;
						end
					end else begin
						timer_q <= timer_q - 16'h0001;
					end
				end
				ST_ANNOUN: begin
					if (key_press_in) begin
						state_q           <= ST_RESULT;
						display_item_out  <= `RRTS_DISP_RESULT;
						display_value_out <= count_msb;
						if (step_q == `RRTS_STEP_REF) begin
							ref_fault_out <= (count_msb < `RRTS_REF_LOW) ||
								(count_msb > `RRTS_REF_HIGH);
						end
					end
				end
				ST_RESULT: begin
					if (key_press_in) begin
						if (step_q == `RRTS_STEP_I90) begin
							state_q           <= ST_VGAIN;
							display_item_out  <= `RRTS_DISP_VGAIN;
							display_value_out <= {13'h0000, sel_vcode};
						end else begin
							step_q           <= step_q + 3'h1;
							state_q          <= ST_ANNOUN;
							display_item_out <= `RRTS_DISP_STEP;
						end
					end
				end
				ST_VGAIN: begin
					if (key_press_in) begin
						state_q           <= ST_IGAIN;
						display_item_out  <= `RRTS_DISP_IGAIN;
						display_value_out <= {13'h0000, sel_icode};
					end
				end
				ST_IGAIN: begin
					if (key_press_in) begin
						state_q  <= ST_IDLE;
						done_out <= 1'b1;
					end
				end
				ST_CYCLE: begin
					if (!start_in && mode_select_in == `RRTS_MODE_IDLE) begin
						state_q <= ST_IDLE;
					end else if (dwell_q == 8'h01) begin
						dwell_q <= `RRTS_CYCLE_DWELL;
						if (step_q == `RRTS_STEP_I90) begin
							step_q <= `RRTS_STEP_REF;
						end else begin
							step_q <= step_q + 3'h1;
						end
					end else begin
						dwell_q <= dwell_q - 8'h01;
					end
				end
				ST_RANGE: begin
					// walk ranges, end after top current range
					if (key_press_in) begin
						if (range_q == 4'h7) begin
							state_q  <= ST_IDLE;
							done_out <= 1'b1;
						end else begin
							range_q           <= range_q + 4'h1;
							display_value_out <= {13'h0000, range_q[2:0] + 3'h1};
							if (range_q >= 4'h3) begin
								display_item_out  <= `RRTS_DISP_IGAIN;
								display_value_out <= {13'h0000, range_q[2:0] - 3'h2};
							end
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// ---- dv/rrts_analog_model.sv ----
// Behavioural analog path that feeds the integrator count
`timescale 1ns/1ns
module rrts_analog_model (
	input  wire        gain_a_in,
	input  wire        gain_b_in,
	input  wire        vsel_in,
	input  wire        conv_gain_in,
	input  wire        phase_in,
	input  wire [15:0] ref_level_in,
	output wire [23:0] count_out
);
	// ***
	// Integrator result
	// ***
	wire [4:0] ln = {gain_a_in, gain_b_in, vsel_in, conv_gain_in, phase_in};
	assign count_out = (ln[4:2] == 3'h0) ? {ref_level_in, 8'h5a} : {8'h40, 3'h0, ln, 8'ha5};
endmodule

// ---- dv/rrts_sequencer_props.sv ----
// Checker for the sequencer outputs
`timescale 1ns/1ns
`include "rrts_regs.vh"
module rrts_props (
	input wire        clock_in,
	input wire        reset_in,
	input wire [1:0]  mode_select_in,
	input wire [23:0] integrator_count_in,
	input wire        amp_gain_select_a_out,
	input wire        amp_gain_select_b_out,
	input wire        voltage_input_select_out,
	input wire        current_converter_gain_out,
	input wire        phase_select_out,
	input wire [2:0]  step_out,
	input wire [2:0]  voltage_gain_code_out,
	input wire [2:0]  current_gain_code_out,
	input wire [2:0]  display_item_out,
	input wire [15:0] display_value_out,
	input wire        ref_fault_out,
	input wire        done_out
);
	// ***
	// Properties
	// ***
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in);
	wire [3:0] ln = {amp_gain_select_a_out, amp_gain_select_b_out,
		voltage_input_select_out, current_converter_gain_out};
	wire [2:0] vc = voltage_gain_code_out;
	wire [2:0] ic = current_gain_code_out;
	wire       res = display_item_out == `RRTS_DISP_RESULT;
	wire       ban = display_item_out == `RRTS_DISP_BANNER;
	reg  [7:0] ban_q;
	always @(posedge clock_in or posedge reset_in)
		if (reset_in) ban_q <= 8'h00;
		else ban_q <= ban ? ban_q + 8'h01 : 8'h00;
	function [3:0] venc(input [2:0] c);
		venc = (c == 3'h1) ? 4'ha : (c == 3'h2) ? 4'h6 : 4'he;
	endfunction
	function [3:0] ienc(input [2:0] c);
		ienc = (c == 3'h1) ? 4'h8 : (c == 3'h2) ? 4'h4 : (c == 3'h3) ? 4'h5 : 4'hd;
	endfunction
	a_inhibit_lines: assert property (vc == 3'h0 && ic == 3'h0 && $stable({vc, ic}) |-> ln[3:1] == 3'h0)
		else $error("inhibit lines wrong");
	a_volt_lines: assert property (vc inside {[1:3]} && $stable(vc) |-> ln == venc(vc))
		else $error("voltage lines wrong");
	a_curr_lines: assert property (ic inside {[1:4]} && $stable(ic) |-> ln == ienc(ic))
		else $error("current lines wrong");
	a_phase_step: assert property (phase_select_out |-> step_out inside {3'h2, 3'h4} || $past(step_out) inside {3'h2, 3'h4})
		else $error("phase high off a 90 degree step");
	a_banner_len: assert property ($fell(ban) |-> ban_q == 8'h7d)
		else $error("banner length wrong");
	a_result_value: assert property ($rose(res) |-> display_value_out == $past(integrator_count_in[23:8]))
		else $error("result not upper counter bits");
	a_ref_window: assert property ($rose(res) && step_out == 3'h0 |-> ref_fault_out == (display_value_out < 16'h6f00 || display_value_out > 16'h8b00))
		else $error("reference fault flag wrong");
	a_cycle_quiet: assert property (mode_select_in == `RRTS_MODE_CYCLE |-> !res)
		else $error("result shown in full cycle");
	a_done_pulse: assert property (done_out |=> !done_out)
		else $error("done longer than a cycle");
	c_done: cover property ($rose(done_out));
	c_fault: cover property ($rose(ref_fault_out));
	c_igain4: cover property (ic == 3'h4 && $stable(ic));
endmodule
bind rrts_sequencer rrts_props u_props (.clock_in(clock_in), .reset_in(reset_in),
	.mode_select_in(mode_select_in), .integrator_count_in(integrator_count_in),
	.amp_gain_select_a_out(amp_gain_select_a_out), .amp_gain_select_b_out(amp_gain_select_b_out),
	.voltage_input_select_out(voltage_input_select_out), .phase_select_out(phase_select_out),
	.current_converter_gain_out(current_converter_gain_out), .step_out(step_out),
	.voltage_gain_code_out(voltage_gain_code_out), .current_gain_code_out(current_gain_code_out),
	.display_item_out(display_item_out), .display_value_out(display_value_out),
	.ref_fault_out(ref_fault_out), .done_out(done_out));

// ---- dv/test_rcl_range_test_sequencer.sv ----
// Self-checking bench for the sequencer
`timescale 1ns/1ns
`include "rrts_regs.vh"
module test_rcl_range_test_sequencer;
	reg         clock_in = 1'b0;
	reg         reset_in = 1'b1;
	reg  [1:0]  mode_q = 2'h0;
	reg         start_q = 1'b0;
	reg         key_q = 1'b0;
	reg  [2:0]  zc_q = 3'h0;
	reg  [15:0] lvl_q = 16'h7d00;
	wire [23:0] cnt;
	wire        a, b, voltage_input_select, ccg, ph, busy, done, flt;
	wire [2:0]  stp, vc, ic, item;
	wire [15:0] val;
	integer     bad_count = 0;
	integer     samples_checked = 0;
	integer     seed = 13;
	integer     r, s, k, n;
	always #4 clock_in = ~clock_in;
	rrts_sequencer u_dut (.clock_in(clock_in), .reset_in(reset_in), .mode_select_in(mode_q),
		.start_in(start_q), .key_press_in(key_q), .impedance_class_in(zc_q),
		.integrator_count_in(cnt), .amp_gain_select_a_out(a), .amp_gain_select_b_out(b),
		.voltage_input_select_out(voltage_input_select), .current_converter_gain_out(ccg),
		.phase_select_out(ph), .step_out(stp), .voltage_gain_code_out(vc),
		.current_gain_code_out(ic), .display_item_out(item), .display_value_out(val),
		.ref_fault_out(flt), .busy_out(busy), .done_out(done));
	rrts_analog_model u_ana (.gain_a_in(a), .gain_b_in(b), .vsel_in(voltage_input_select),
		.conv_gain_in(ccg), .phase_in(ph), .ref_level_in(lvl_q), .count_out(cnt));
	// ***
	// Helpers
	// ***
	task chk(input [63:0] nm, input [15:0] got, input [15:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("[ERR] %0s exp %h got %h", nm, exp, got);
			end
		end
	endtask
	task tally_and_finish;
		begin
			if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
			else $display("Some tests failed");
			$finish;
		end
	endtask
	task wait_on(input [2:0] it);
		begin
			n = 0;
			while (((it == 3'h7) ? done !== 1'b1 : item !== it) && n < 400) begin
				@(negedge clock_in);
				n = n + 1;
			end
			if (n >= 400) begin
				bad_count = bad_count + 1;
				tally_and_finish;
			end
		end
	endtask
	task press;
		begin
			key_q = 1'b1;
			@(negedge clock_in);
			key_q = 1'b0;
			repeat (3) @(negedge clock_in);
		end
	endtask
	function [2:0] vcode(input [2:0] z);
		vcode = (z == 3'h0) ? 3'h3 : (z == 3'h1) ? 3'h2 : 3'h1;
	endfunction
	function [2:0] icode(input [2:0] z);
		icode = (z < 3'h3) ? 3'h1 : z - 3'h1;
	endfunction
	function [3:0] enc(input v, input [2:0] c);
		if (c == 3'h0) enc = 4'h0;
		else if (v) enc = (c == 3'h1) ? 4'ha : (c == 3'h2) ? 4'h6 : 4'he;
		else enc = (c == 3'h1) ? 4'h8 : (c == 3'h2) ? 4'h4 : (c == 3'h3) ? 4'h5 : 4'hd;
	endfunction
	// ***
	// Scenarios
	// ***
	initial begin
		repeat (16) @(negedge clock_in);
		reset_in = 1'b0;
		for (r = 0; r < 8; r = r + 1) begin
			zc_q = (r < 6) ? r[2:0] : 3'({$random(seed)} % 6);
			lvl_q = (r == 0) ? 16'h6f00 : (r == 1) ? 16'h8b00 : (r == 2) ? 16'h6eff :
				(r == 3) ? 16'h8b01 : 16'($random(seed));
			mode_q = `RRTS_MODE_SINGLE;
			start_q = 1'b1;
			@(negedge clock_in);
			start_q = 1'b0;
			press;
			for (s = 0; s < 5; s = s + 1) begin
				wait_on(`RRTS_DISP_STEP);
				@(negedge clock_in);
				chk("step", stp, s[2:0]);
				press;
				wait_on(`RRTS_DISP_RESULT);
				chk("value", val, cnt[23:8]);
				chk("lines", {a, b, voltage_input_select, ccg}, enc(s < 3, (s == 0) ? 3'h0 : (s < 3) ? vcode(zc_q) : icode(zc_q)));
				chk("codes", {vc, ic}, (s == 0) ? 6'h00 : (s < 3) ? {vcode(zc_q), 3'h0} : {3'h0, icode(zc_q)});
				chk("phase", ph, s == 2 || s == 4);
				if (s == 0) chk("fault", flt, lvl_q < 16'h6f00 || lvl_q > 16'h8b00);
				press;
			end
			wait_on(`RRTS_DISP_VGAIN);
			chk("vgain", val, vcode(zc_q));
			press;
			wait_on(`RRTS_DISP_IGAIN);
			chk("igain", val, icode(zc_q));
			key_q = 1'b1;
			@(negedge clock_in);
			key_q = 1'b0;
			chk("done", done, 16'h0001);
			repeat (3) @(negedge clock_in);
			chk("idle", busy, 16'h0000);
		end
		mode_q = `RRTS_MODE_RANGE;
		start_q = 1'b1;
		@(negedge clock_in);
		start_q = 1'b0;
		wait_on(`RRTS_DISP_VGAIN);
		repeat (2) @(negedge clock_in);
		for (k = 0; k < 8; k = k + 1) begin
			if (k > 0) press;
			chk("rg item", item, (k < 4) ? `RRTS_DISP_VGAIN : `RRTS_DISP_IGAIN);
			chk("rg code", val, (k < 4) ? k[2:0] : k[2:0] - 3'h3);
			chk("rg lines", {a, b, voltage_input_select, ccg}, enc(k < 4, (k < 4) ? k[2:0] : k[2:0] - 3'h3));
			chk("rg codes", {vc, ic}, (k < 4) ? {k[2:0], 3'h0} : {3'h0, k[2:0] - 3'h3});
		end
		key_q = 1'b1;
		@(negedge clock_in);
		key_q = 1'b0;
		chk("rg done", done, 16'h0001);
		mode_q = `RRTS_MODE_CYCLE;
		start_q = 1'b1;
		@(negedge clock_in);
		start_q = 1'b0;
		repeat (700) @(negedge clock_in);
		chk("cyc busy", busy, 16'h0001);
		chk("cyc item", item, `RRTS_DISP_NONE);
		mode_q = `RRTS_MODE_IDLE;
		repeat (8) @(negedge clock_in);
		chk("cyc idle", busy, 16'h0000);
		tally_and_finish;
	end
endmodule
